// *** hdl/pcc_consts.svh ***
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// ----------------------------------------
// command word location and layout
// ----------------------------------------
`define PCC_CMD_OFFSET      8'h04
`define PCC_CMD_RESET       16'h0000
`define PCC_STAT_RESET      16'h0000
`define PCC_CMD_WR_MASK     16'hFF57
`define PCC_BIT_IO_SPACE    0
`define PCC_BIT_MEM_SPACE   1
`define PCC_BIT_MASTER      2
`define PCC_BIT_SPECIAL     3
`define PCC_BIT_MWI         4
`define PCC_BIT_PALETTE     5
`define PCC_BIT_PAR_RESP    6
`define PCC_BIT_STEPPING    7
`define PCC_BIT_SYS_ERR     8
`define PCC_BIT_FAST_B2B    9
`define PCC_STAT_BIT_DPE    15

`endif

// *** hdl/pcc_pkg.sv ***
package pcc_pkg;

    // configuration-space request from the bus target logic
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcc_cfg_req_t;

    // kind of target access being claimed on the bus
    typedef struct packed {
        logic cfg;
        logic mem;
        logic io;
    } pcc_access_t;

    // decoded command-word controls handed to the function's bus logic
    typedef struct packed {
        logic io_space_enable;
        logic memory_space_enable;
        logic master_enable;
        logic write_invalidate_enable;
        logic parity_error_response;
        logic system_error_enable;
        logic fast_b2b_enable;
    } pcc_ctrl_t;

endpackage

// *** hdl/pcc_parity_gen.sv ***
`timescale 1ns/100ps

// parity over address/data and command/byte enables, one clock after the data phase
module pcc_parity_gen (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe,
    output logic             par
);

    // ----------------------------------------
    // even parity, never gated by the response bit
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            par <= 1'b0;
        end else begin
            par <= ^{ad, cbe};
        end
    end

endmodule

// *** hdl/pcc_command.sv ***
`timescale 1ns/100ps
`include "pcc_consts.svh"

// What this block does
// - 16-bit command word lives at configuration offset 04h.
// - All-zero command word: only configuration accesses are answered.
// - Bit 9 fast back-to-back enable, resets 0; 1 allows different agents.
// - Bit 8 system error enable, resets 0, gates the system error driver.
// - Address parity errors reported only when bits 8 and 6 both set.
// - Bit 7 stepping control is read-only zero.
// - Bit 6 parity error response, read/write, resets 0, enables normal action.
// - Response off: parity error sets status bit 15, no parity error pin.
// - Correct parity is always generated, even with checking disabled.
// - Bit 5 palette snoop control is read-only zero.
// - Master enable low: no bus access is initiated.
// - Memory space enable resets 0; 1 allows memory access response.
module pcc_command (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire pcc_pkg::pcc_cfg_req_t cfg_req,
    output logic [31:0]               cfg_rdata,
    output logic                      cfg_rvalid,
    input  wire pcc_pkg::pcc_access_t access,
    output logic                      access_claim,
    input  wire logic                 master_req,
    output logic                      master_go,
    input  wire logic                 data_parity_err,
    input  wire logic                 addr_parity_err,
    output logic                      perr_n_o,
    output logic                      perr_oe,
    output logic                      serr_n_o,
    output logic                      serr_oe,
    input  wire logic [31:0]          ad_out,
    input  wire logic [3:0]           cbe_out,
    output logic                      par_out,
    output pcc_pkg::pcc_ctrl_t        ctrl
);

    logic [15:0] pci_command_word;
    logic        parity_error_detected;
    logic        cmd_hit;
    logic [15:0] next_cmd;
    logic [15:0] wr_bytes;

    // ----------------------------------------
    // command word storage
    // ----------------------------------------
    assign cmd_hit  = (cfg_req.addr == `PCC_CMD_OFFSET);
    assign wr_bytes = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}} & `PCC_CMD_WR_MASK;
    // read-only bits 7, 5 and 3 never enter the mask, so they stay zero
    assign next_cmd = (pci_command_word & ~wr_bytes) | (cfg_req.wdata[15:0] & wr_bytes);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pci_command_word <= `PCC_CMD_RESET;
        end else if (cfg_req.wr && cmd_hit) begin
            pci_command_word <= next_cmd;
        end
    end

    assign ctrl.io_space_enable         = pci_command_word[`PCC_BIT_IO_SPACE];
    assign ctrl.memory_space_enable     = pci_command_word[`PCC_BIT_MEM_SPACE];
    assign ctrl.master_enable           = pci_command_word[`PCC_BIT_MASTER];
    assign ctrl.write_invalidate_enable = pci_command_word[`PCC_BIT_MWI];
    assign ctrl.parity_error_response   = pci_command_word[`PCC_BIT_PAR_RESP];
    assign ctrl.system_error_enable     = pci_command_word[`PCC_BIT_SYS_ERR];
    assign ctrl.fast_b2b_enable         = pci_command_word[`PCC_BIT_FAST_B2B];

    // ----------------------------------------
    // configuration read port
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_req.rd;
            if (cfg_req.rd && cmd_hit) begin
                cfg_rdata <= {parity_error_detected, 15'h0000, pci_command_word};
            end else begin
                // unmapped offsets read as zero
                cfg_rdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // target claim and master gating
    // ----------------------------------------
    // a zero word leaves only configuration cycles, which keeps enumeration possible
    assign access_claim = access.cfg
                        | (access.mem & ctrl.memory_space_enable)
                        | (access.io & ctrl.io_space_enable);
    assign master_go    = master_req & ctrl.master_enable;

    // ----------------------------------------
    // parity error handling
    // ----------------------------------------
    // status bit is sticky: only reset clears it, since the status word is read-only here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            parity_error_detected <= 1'b0;
        end else if (data_parity_err || addr_parity_err) begin
            parity_error_detected <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            perr_n_o <= 1'b1;
            perr_oe  <= 1'b0;
        end else begin
            perr_n_o <= ~(data_parity_err & ctrl.parity_error_response);
            perr_oe  <= data_parity_err & ctrl.parity_error_response;
        end
    end

    // system error is open drain: the driver is enabled only while pulling low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serr_n_o <= 1'b1;
            serr_oe  <= 1'b0;
        end else begin
            serr_n_o <= ~(addr_parity_err & ctrl.system_error_enable
                          & ctrl.parity_error_response);
            serr_oe  <= addr_parity_err & ctrl.system_error_enable
                      & ctrl.parity_error_response;
        end
    end

    // ----------------------------------------
    // parity generation
    // ----------------------------------------
    pcc_parity_gen u_par (
        .clk  (clk),
        .nrst (nrst),
        .ad   (ad_out),
        .cbe  (cbe_out),
        .par  (par_out)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_cmd_write;
        cfg_req.wr && cmd_hit && cfg_req.be[0];
    endsequence

    sequence s_cmd_read;
        cfg_req.rd && cmd_hit;
    endsequence

    sequence s_perr_enabled_err;
        data_parity_err && ctrl.parity_error_response;
    endsequence

    AST_WRITE_LANDS: assert property (
        s_cmd_write |=> (pci_command_word[2:0] == $past(cfg_req.wdata[2:0])))
        else $error("command low bits did not take the written value");

    // compares against the stored word, so it also covers reads long after the write
    AST_READBACK: assert property (
        s_cmd_read |=> (cfg_rvalid && (cfg_rdata[15:0] == $past(pci_command_word))
                        && (cfg_rdata[31] == $past(parity_error_detected))))
        else $error("command read did not return the stored word");

    AST_RVALID_PULSE: assert property (
        cfg_rvalid == $past(cfg_req.rd))
        else $error("read valid is not a one-cycle echo of the read request");

    AST_ZERO_ONLY_CFG: assert property (
        (pci_command_word == 16'h0000) |-> (access_claim == access.cfg))
        else $error("zero command word claimed a non-configuration access");

    AST_STEP_PALETTE_ZERO: assert property (
        !pci_command_word[`PCC_BIT_STEPPING] && !pci_command_word[`PCC_BIT_PALETTE]
        && !pci_command_word[`PCC_BIT_SPECIAL])
        else $error("read-only command bit became set");

    AST_MASTER_GATED: assert property (
        !ctrl.master_enable |-> !master_go)
        else $error("master access started while master enable is low");

    AST_IO_CLAIM: assert property (
        (access.io && !access.cfg && !access.mem) |-> (access_claim == ctrl.io_space_enable))
        else $error("io claim disagrees with io space enable");

    AST_MEM_CLAIM: assert property (
        (access.mem && !access.cfg && !access.io) |-> (access_claim == ctrl.memory_space_enable))
        else $error("memory claim disagrees with memory space enable");

    AST_SERR_NEEDS_BOTH: assert property (
        !serr_n_o |-> $past(ctrl.system_error_enable && ctrl.parity_error_response
                            && addr_parity_err))
        else $error("system error driven without both enables");

    AST_SERR_REPORTED: assert property (
        (addr_parity_err && ctrl.system_error_enable && ctrl.parity_error_response)
            |=> (!serr_n_o && serr_oe))
        else $error("enabled address parity error not reported");

    AST_PERR_SILENT: assert property (
        (data_parity_err && !ctrl.parity_error_response)
            |=> (perr_n_o && !perr_oe && parity_error_detected))
        else $error("parity error pin driven with response off, or status not set");

    AST_PERR_ACTIVE: assert property (
        s_perr_enabled_err |=> (!perr_n_o && perr_oe))
        else $error("parity error pin not asserted with response on");

    // only reset may clear the detected flag; the status word has no write path
    AST_DPE_STICKY: assert property (
        parity_error_detected |=> parity_error_detected)
        else $error("detected parity error flag cleared without reset");

    AST_PARITY_ALWAYS: assert property (
        ##1 (par_out == $past(^{ad_out, cbe_out})))
        else $error("generated parity incorrect");

    AST_FBB_FOLLOWS: assert property (
        s_cmd_write ##0 cfg_req.be[1] |=> (ctrl.fast_b2b_enable == $past(cfg_req.wdata[9])))
        else $error("fast back-to-back enable did not follow the write");

endmodule

// *** tb/pcc_host_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// configuration host model
// ----------------------------------------
module pcc_host_model #(
    parameter bit ALL_FAST_B2B = 1'b1
) (
    input  wire logic             clk,
    output pcc_pkg::pcc_cfg_req_t cfg_req,
    input  wire logic [31:0]      cfg_rdata,
    input  wire logic             cfg_rvalid
);
    initial cfg_req = '0;

    // idle bus shows inverted leftovers so stale values never pass for live ones
    task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be,
                             input logic [15:0] data);
        logic [15:0] d;
        d = data;
        if (addr == 8'h04) begin
            d[15:10] = 6'h00;
            if (!ALL_FAST_B2B) begin
                d[9] = 1'b0;
            end
        end
        @(negedge clk);
        cfg_req = '{1'b0, 1'b1, addr, be, {16'h0000, d}};
        @(negedge clk);
        cfg_req = '{1'b0, 1'b0, ~addr, ~be, ~cfg_req.wdata};
    endtask

    task automatic cfg_read(input logic [7:0] addr, output logic [31:0] data,
                            output bit ok);
        @(negedge clk);
        cfg_req = '{1'b1, 1'b0, addr, 4'hF, cfg_req.wdata};
        @(negedge clk);
        cfg_req = '{1'b0, 1'b0, ~addr, 4'h0, ~cfg_req.wdata};
        ok = 1'b0;
        data = 32'h0000_0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (cfg_rvalid === 1'b1) begin
                ok = 1'b1;
                data = cfg_rdata;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule

// *** tb/test_pcc_command.sv ***
`timescale 1ns/100ps

module test_pcc_command;
    logic                  clk;
    logic                  nrst;
    pcc_pkg::pcc_cfg_req_t cfg_req;
    logic [31:0]           cfg_rdata;
    logic                  cfg_rvalid;
    pcc_pkg::pcc_access_t  access;
    logic                  access_claim;
    logic                  master_req;
    logic                  master_go;
    logic                  data_parity_err;
    logic                  addr_parity_err;
    logic                  perr_n_o;
    logic                  perr_oe;
    logic                  serr_n_o;
    logic                  serr_oe;
    logic [31:0]           ad_out;
    logic [3:0]            cbe_out;
    logic                  par_out;
    pcc_pkg::pcc_ctrl_t    ctrl;
    logic [31:0]           rd_data;
    bit                    rd_ok;
    logic [15:0]           cmd;
    int                    n_fail;
    int                    comparisons;

    pcc_command u_pcc_command (.clk(clk), .nrst(nrst), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .access(access),
        .access_claim(access_claim), .master_req(master_req), .master_go(master_go),
        .data_parity_err(data_parity_err), .addr_parity_err(addr_parity_err),
        .perr_n_o(perr_n_o), .perr_oe(perr_oe), .serr_n_o(serr_n_o), .serr_oe(serr_oe),
        .ad_out(ad_out), .cbe_out(cbe_out), .par_out(par_out), .ctrl(ctrl));

    pcc_host_model u_pcc_host_model (.clk(clk), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic read_check(input logic [7:0] addr, input logic [31:0] exp);
        u_pcc_host_model.cfg_read(addr, rd_data, rd_ok);
        if (!rd_ok) begin
            n_fail++;
            finish_test();
        end
        check("cfg_rdata", exp, rd_data);
    endtask

    task automatic gate(input logic [2:0] kind, input logic exp);
        @(negedge clk);
        access = kind;
        #1;
        check("access_claim", 32'(exp), 32'(access_claim));
    endtask

    // both error pulses land together; pins answer one cycle later for one cycle
    task automatic err_pulse(input logic exp_perr, input logic exp_serr);
        @(negedge clk);
        data_parity_err = 1'b1;
        addr_parity_err = 1'b1;
        @(negedge clk);
        data_parity_err = 1'b0;
        addr_parity_err = 1'b0;
        check("perr_oe", 32'(exp_perr), 32'(perr_oe));
        check("perr_n_o", 32'(!exp_perr), 32'(perr_n_o));
        check("serr_oe", 32'(exp_serr), 32'(serr_oe));
        check("serr_n_o", 32'(!exp_serr), 32'(serr_n_o));
        @(negedge clk);
        check("perr_oe", 32'h0, 32'(perr_oe));
    endtask

    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial begin
        nrst = 1'b0;
        access = '0;
        master_req = 1'b1;
        data_parity_err = 1'b0;
        addr_parity_err = 1'b0;
        ad_out = 32'h0;
        cbe_out = 4'h0;
        n_fail = 0;
        comparisons = 0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        read_check(8'h04, 32'h0000_0000);
        gate(3'b011, 1'b0);
        gate(3'b100, 1'b1);
        check("master_go", 32'h0, 32'(master_go));
        u_pcc_host_model.cfg_write(8'h04, 4'h3, 16'hFFFF);
        read_check(8'h04, 32'h0000_0357);
        check("fast_b2b_enable", 32'h1, 32'(ctrl.fast_b2b_enable));
        check("master_go", 32'h1, 32'(master_go));
        check("ctrl", 32'h0000_007F, 32'(ctrl));
        gate(3'b010, 1'b1);
        gate(3'b001, 1'b1);
        u_pcc_host_model.cfg_write(8'h08, 4'h3, 16'h0000);
        read_check(8'h08, 32'h0000_0000);
        read_check(8'h04, 32'h0000_0357);
        u_pcc_host_model.cfg_write(8'h04, 4'h2, 16'h0000);
        read_check(8'h04, 32'h0000_0057);
        check("ctrl", 32'h0000_007C, 32'(ctrl));
        for (int i = 0; i < 4; i++) begin
            cmd = {7'h00, i[1], 1'b0, i[0], 6'h00};
            u_pcc_host_model.cfg_write(8'h04, 4'h3, cmd);
            err_pulse(i[0], i[0] & i[1]);
            read_check(8'h04, {16'h8000, cmd});
        end
        u_pcc_host_model.cfg_write(8'h04, 4'h3, 16'h0000);
        gate(3'b011, 1'b0);
        for (int j = 0; j < 4; j++) begin
            @(negedge clk);
            ad_out = 32'h0000_0003 << j;
            cbe_out = 4'(j);
            @(negedge clk);
            check("par_out", 32'(^{ad_out, cbe_out}), 32'(par_out));
        end
        finish_test();
    end
endmodule
